//--- vic_defs.svh
// constants of the vectored interrupt controller
`ifndef VIC_DEFS_SVH
`define VIC_DEFS_SVH

// register offsets
`define VIC_ADDR_FLAG0    4'h0
`define VIC_ADDR_MASK0    4'h3
`define VIC_ADDR_ENAB0    4'h6
`define VIC_ADDR_EXTMODE0 4'h9
`define VIC_ADDR_EXTMODE1 4'hA
`define VIC_ADDR_KEYMODE  4'hB
`define VIC_ADDR_CTRL     4'hC
`define VIC_ADDR_STATUS   4'hD

// reset values
`define VIC_FLAG_RST      21'h000000
`define VIC_MASK_RST      21'h1FFFFF
`define VIC_ENAB_RST      21'h000000
`define VIC_EXTMODE_RST   8'h00
`define VIC_KEYMODE_RST   8'h00
`define VIC_CTRL_RST      2'h0

// control register fields
`define VIC_CTRL_WDT_NMI  0
`define VIC_CTRL_CASCADE  1

// source count and bytes per flag group
`define VIC_NSRC          21
`define VIC_NBYTE         3

// default priorities, 0 highest
`define VIC_PRI_WDT       0
`define VIC_PRI_PIN0      1
`define VIC_PRI_REMEDGE   5
`define VIC_PRI_RXSERA    6
`define VIC_PRI_SERB      7
`define VIC_PRI_UARTTX    8
`define VIC_PRI_WATCHINT  9
`define VIC_PRI_T16       10
`define VIC_PRI_T8A       11
`define VIC_PRI_T8B       12
`define VIC_PRI_T8C       13
`define VIC_PRI_CONV      14
`define VIC_PRI_WATCHOVF  15
`define VIC_PRI_KEY       16
`define VIC_PRI_REMERR    17
`define VIC_PRI_REMGUIDE  18
`define VIC_PRI_REMRX     19
`define VIC_PRI_REMSHIFT  20

// vectors: maskable entry is base plus twice the priority
`define VIC_VEC_NMI       16'h0004
`define VIC_VEC_BASE      16'h0004
`define VIC_VEC_RST       16'h0000

`endif

//--- vic_pkg.sv
// types shared by the vectored interrupt controller
package vic_pkg;
    typedef logic [20:0] vic_src_type;
    typedef logic [4:0]  vic_prio_type;
    typedef logic [3:0]  vic_addr_type;
    typedef logic [7:0]  vic_byte_type;
    typedef logic [15:0] vic_vec_type;
    typedef enum logic [1:0] {
        VIC_EDGE_FALL,
        VIC_EDGE_RISE,
        VIC_EDGE_NONE,
        VIC_EDGE_BOTH
    } vic_edge_type;
endpackage

//--- vic_top.sv
// vectored interrupt controller: flags, priority and vector
//
// Notes on behaviour
// - non-maskable request is taken even with interrupts globally off.
// - non-maskable request beats every maskable one and skips priority arbitration.
// - standby release rises for a non-maskable or any unmasked maskable request.
// - only the watchdog overflow in watchdog mode is non-maskable, vector 0004h.
// - watchdog overflow feeds the non-maskable or the maskable request, never both.
// - 5 external and 16 internal maskable sources, 21 sources in all.
// - simultaneous maskable requests are served in fixed default priority order.
// - priority 0 is highest and priority 20 is lowest.
// - watchdog overflow in interval timer mode has priority 0.
// - the four pin edge requests take priorities 1 to 4 in pin order.
// - remote edge at 5 up to watch overflow at 15 map to vectors 000eh..0022h.
// - uart receive done and serial a transfer done share priority 6.
// - serial b done is 7, uart transmit done 8, watch interval 9.
// - timer matches take 10 to 13; 12 uses the 16-bit match when cascaded.
// - conversion done is priority 14, watch overflow is priority 15.
// - key return is an external source at priority 16, vector 0024h.
// - remote error, guide pulse, receive done, shift read take 17 to 20, 0026h..002ch.
// - each source has request, enable and mask flags; a set mask blocks service.
// - edge modes pick the pin edge behaviour, key return mode picks key lines.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "vic_defs.svh"

module vic_top (
    input  wire logic                clk_sys,                // system clock
    input  wire logic                arst_n,                 // async reset
    input  wire vic_pkg::vic_addr_type reg_addr,             // register address
    input  wire vic_pkg::vic_byte_type reg_wdata,            // register write data
    input  wire logic                reg_we,                 // register write strobe
    input  wire logic                reg_re,                 // register read strobe
    output vic_pkg::vic_byte_type    reg_rdata,              // read data, cycle after strobe
    input  wire logic                watchdog_irq,           // watchdog overflow pulse
    input  wire logic                pin_edge_irq_0,         // external pin 0 level
    input  wire logic                pin_edge_irq_1,         // external pin 1 level
    input  wire logic                pin_edge_irq_2,         // external pin 2 level
    input  wire logic                pin_edge_irq_3,         // external pin 3 level
    input  wire logic                remote_edge_irq,        // remote receiver edge pulse
    input  wire logic                uart_rx_done_irq,       // uart receive done pulse
    input  wire logic                serial_a_xfer_done_irq, // serial a transfer end pulse
    input  wire logic                serial_b_xfer_done_irq, // serial b transfer end pulse
    input  wire logic                uart_tx_done_irq,       // uart transmit end pulse
    input  wire logic                watch_interval_irq,     // watch interval pulse
    input  wire logic                timer16_match_irq,      // 16-bit timer match pulse
    input  wire logic                timer8a_match_irq,      // 8-bit timer a match pulse
    input  wire logic                timer8b_match_irq,      // 8-bit timer b match pulse
    input  wire logic                cascade_match_irq,      // cascaded 16-bit match pulse
    input  wire logic                timer8c_match_irq,      // 8-bit timer c match pulse
    input  wire logic                conversion_done_irq,    // conversion end pulse
    input  wire logic                watch_overflow_irq,     // watch overflow pulse
    input  wire logic [7:0]          key_lines,              // key return port levels
    input  wire logic                remote_error_irq,       // remote receive error pulse
    input  wire logic                remote_guide_pulse_irq, // remote guide pulse
    input  wire logic                remote_rx_done_irq,     // remote receive done pulse
    input  wire logic                remote_shift_read_irq,  // remote shift read pulse
    input  wire logic                cpu_int_enable,         // cpu global interrupt enable
    input  wire logic                cpu_ack,                // cpu acknowledge pulse
    output logic                     nmi_req,                // non-maskable request level
    output logic                     irq_req,                // maskable request level
    output vic_pkg::vic_vec_type     vector_addr,            // vector table address
    output logic                     standby_release         // wake from halt or stop
);
    import vic_pkg::*;

    vic_src_type  flag_reg;
    vic_src_type  flag_next;
    vic_src_type  mask_reg;
    vic_src_type  enab_reg;
    vic_byte_type ext_mode_0_reg;
    vic_byte_type ext_mode_1_reg;
    vic_byte_type key_return_mode_reg;
    logic [1:0]   ctrl_reg;
    logic         nmi_pend_reg;
    vic_prio_type win_reg;
    vic_src_type  src_ev;
    vic_src_type  ack_clr;
    vic_src_type  svc;
    logic [3:0]   pin_prev_reg;
    logic [3:0]   pin_cur;
    logic [3:0]   pin_hit;
    logic [7:0]   key_prev_reg;
    logic         key_hit;
    logic         wdt_nmi_mode;
    logic         nmi_ev;

    // edge test under a two-bit mode
    function automatic logic edge_hit(input vic_edge_type m, input logic p, input logic c);
        logic r;
        r = 1'b0;
        unique case (m)
            VIC_EDGE_FALL: r = p & ~c;
            VIC_EDGE_RISE: r = ~p & c;
            VIC_EDGE_NONE: r = 1'b0;
            VIC_EDGE_BOTH: r = p ^ c;
        endcase
        return r;
    endfunction

    // lowest set index wins
    function automatic vic_prio_type first_set(input vic_src_type v);
        vic_prio_type r;
        r = 5'h00;
        for (int i = `VIC_NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = vic_prio_type'(i);
            end
        end
        return r;
    endfunction

    // byte view of a flag group; unused top bits read zero
    function automatic vic_byte_type grp_rd(input vic_src_type v, input int b);
        logic [23:0] w;
        w = {3'h0, v};
        return w[b*8 +: 8];
    endfunction

    // byte write into a flag group
    function automatic vic_src_type grp_wr(input vic_src_type v, input vic_addr_type base,
                                           input vic_addr_type a, input vic_byte_type d,
                                           input logic we);
        logic [23:0] w;
        w = {3'h0, v};
        for (int b = 0; b < `VIC_NBYTE; b++) begin
            if (we && a == base + vic_addr_type'(b)) begin
                w[b*8 +: 8] = d;
            end
        end
        return w[20:0];
    endfunction

    assign wdt_nmi_mode = ctrl_reg[`VIC_CTRL_WDT_NMI];
    // one overflow goes to exactly one of the two watchdog requests
    assign nmi_ev = watchdog_irq & wdt_nmi_mode;

    // pin edges: pins 0-1 in mode register 0, pins 2-3 in mode register 1
    assign pin_cur = {pin_edge_irq_3, pin_edge_irq_2, pin_edge_irq_1, pin_edge_irq_0};
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_pin
            logic [1:0] mode;
            assign mode = (g < 2) ? ext_mode_0_reg[(g % 2)*2 +: 2] : ext_mode_1_reg[(g % 2)*2 +: 2];
            assign pin_hit[g] = edge_hit(vic_edge_type'(mode), pin_prev_reg[g], pin_cur[g]);
        end
    endgenerate

    // key return: falling edge on any selected line
    assign key_hit = |(key_prev_reg & ~key_lines & key_return_mode_reg);

    // previous levels for the edge detectors
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_prev_reg <= 4'h0;
            key_prev_reg <= 8'h00;
        end else begin
            pin_prev_reg <= pin_cur;
            key_prev_reg <= key_lines;
        end
    end

    // source events gathered by default priority index
    always_comb begin
        src_ev                      = '0;
        src_ev[`VIC_PRI_WDT]        = watchdog_irq & ~wdt_nmi_mode;
        src_ev[`VIC_PRI_PIN0 +: 4]  = pin_hit;
        src_ev[`VIC_PRI_REMEDGE]    = remote_edge_irq;
        src_ev[`VIC_PRI_RXSERA]     = uart_rx_done_irq | serial_a_xfer_done_irq;
        src_ev[`VIC_PRI_SERB]       = serial_b_xfer_done_irq;
        src_ev[`VIC_PRI_UARTTX]     = uart_tx_done_irq;
        src_ev[`VIC_PRI_WATCHINT]   = watch_interval_irq;
        src_ev[`VIC_PRI_T16]        = timer16_match_irq;
        src_ev[`VIC_PRI_T8A]        = timer8a_match_irq;
        src_ev[`VIC_PRI_T8B]        = ctrl_reg[`VIC_CTRL_CASCADE] ? cascade_match_irq
                                                                  : timer8b_match_irq;
        src_ev[`VIC_PRI_T8C]        = timer8c_match_irq;
        src_ev[`VIC_PRI_CONV]       = conversion_done_irq;
        src_ev[`VIC_PRI_WATCHOVF]   = watch_overflow_irq;
        src_ev[`VIC_PRI_KEY]        = key_hit;
        src_ev[`VIC_PRI_REMERR]     = remote_error_irq;
        src_ev[`VIC_PRI_REMGUIDE]   = remote_guide_pulse_irq;
        src_ev[`VIC_PRI_REMRX]      = remote_rx_done_irq;
        src_ev[`VIC_PRI_REMSHIFT]   = remote_shift_read_irq;
    end

    // acknowledge clears the source just taken
    always_comb begin
        ack_clr = '0;
        if (cpu_ack && irq_req && !nmi_req) begin
            ack_clr[win_reg] = 1'b1;
        end
    end

    // request flags: a new event wins over write and acknowledge
    always_comb begin
        flag_next = grp_wr(flag_reg, `VIC_ADDR_FLAG0, reg_addr, reg_wdata, reg_we);
        flag_next = (flag_next & ~ack_clr) | src_ev;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flag_reg <= `VIC_FLAG_RST;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // mask and enable flags, software only
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mask_reg <= `VIC_MASK_RST;
            enab_reg <= `VIC_ENAB_RST;
        end else begin
            mask_reg <= grp_wr(mask_reg, `VIC_ADDR_MASK0, reg_addr, reg_wdata, reg_we);
            enab_reg <= grp_wr(enab_reg, `VIC_ADDR_ENAB0, reg_addr, reg_wdata, reg_we);
        end
    end

    // mode and control registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ext_mode_0_reg      <= `VIC_EXTMODE_RST;
            ext_mode_1_reg      <= `VIC_EXTMODE_RST;
            key_return_mode_reg <= `VIC_KEYMODE_RST;
            ctrl_reg            <= `VIC_CTRL_RST;
        end else if (reg_we) begin
            unique case (reg_addr)
                `VIC_ADDR_EXTMODE0: ext_mode_0_reg      <= reg_wdata;
                `VIC_ADDR_EXTMODE1: ext_mode_1_reg      <= reg_wdata;
                `VIC_ADDR_KEYMODE:  key_return_mode_reg <= reg_wdata;
                `VIC_ADDR_CTRL:     ctrl_reg            <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // non-maskable pending: set wins over acknowledge
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            nmi_pend_reg <= 1'b0;
        end else if (nmi_ev) begin
            nmi_pend_reg <= 1'b1;
        end else if (cpu_ack && nmi_req) begin
            nmi_pend_reg <= 1'b0;
        end
    end

    // serviceable sources: flag set, enabled and not masked
    assign svc = flag_reg & enab_reg & ~mask_reg;

    // registered request and vector; dropped a cycle after acknowledge so a cleared flag is not re-offered
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            nmi_req     <= 1'b0;
            irq_req     <= 1'b0;
            win_reg     <= 5'h00;
            vector_addr <= `VIC_VEC_RST;
        end else if (cpu_ack) begin
            nmi_req <= 1'b0;
            irq_req <= 1'b0;
        end else if (nmi_pend_reg) begin
            nmi_req     <= 1'b1;
            irq_req     <= 1'b0;
            vector_addr <= `VIC_VEC_NMI;
        end else begin
            nmi_req     <= 1'b0;
            irq_req     <= |svc & cpu_int_enable;
            win_reg     <= first_set(svc);
            vector_addr <= `VIC_VEC_BASE + {10'h000, first_set(svc), 1'b0};
        end
    end

    // standby release ignores enables: any unmasked request wakes the core
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            standby_release <= 1'b0;
        end else begin
            standby_release <= nmi_pend_reg | (|(flag_reg & ~mask_reg));
        end
    end

    // read data stand one cycle after the strobe, else zero
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_re) begin
            unique case (reg_addr)
                4'h0, 4'h1, 4'h2:   reg_rdata <= grp_rd(flag_reg, int'(reg_addr - `VIC_ADDR_FLAG0));
                4'h3, 4'h4, 4'h5:   reg_rdata <= grp_rd(mask_reg, int'(reg_addr - `VIC_ADDR_MASK0));
                4'h6, 4'h7, 4'h8:   reg_rdata <= grp_rd(enab_reg, int'(reg_addr - `VIC_ADDR_ENAB0));
                `VIC_ADDR_EXTMODE0: reg_rdata <= ext_mode_0_reg;
                `VIC_ADDR_EXTMODE1: reg_rdata <= ext_mode_1_reg;
                `VIC_ADDR_KEYMODE:  reg_rdata <= key_return_mode_reg;
                `VIC_ADDR_CTRL:     reg_rdata <= {6'h00, ctrl_reg};
                `VIC_ADDR_STATUS:   reg_rdata <= {win_reg, standby_release, irq_req, nmi_pend_reg};
                default:            reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

//--- vic_monitor.sv
// port checker for the vectored interrupt controller
`timescale 1ns/1ps
module vic_monitor (
    input wire logic                  clk_sys,        // clock
    input wire logic                  arst_n,         // reset
    input wire vic_pkg::vic_addr_type reg_addr,       // address
    input wire vic_pkg::vic_byte_type reg_wdata,      // write data
    input wire logic                  reg_we,         // write strobe
    input wire logic                  reg_re,         // read strobe
    input wire vic_pkg::vic_byte_type reg_rdata,      // read data
    input wire logic                  watchdog_irq,   // watchdog
    input wire logic                  cpu_int_enable, // global on
    input wire logic                  cpu_ack,        // acknowledge
    input wire logic                  nmi_req,        // nmi offered
    input wire logic                  irq_req,        // irq offered
    input wire vic_pkg::vic_vec_type  vector_addr,    // vector
    input wire logic                  standby_release // wake
);
    import vic_pkg::*;
    logic nmi_mode_reg;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    // shadow the watchdog routing bit from bus writes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            nmi_mode_reg <= 1'b0;
        else if (reg_we && reg_addr == 4'hC)
            nmi_mode_reg <= reg_wdata[0];
    end

    rdata_idle_a: assert property (!$past(reg_re) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    rdata_unmapped_a: assert property ($past(reg_re) && $past(reg_addr) > 4'hD |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    nmi_vec_a: assert property (nmi_req |-> vector_addr == 16'h0004)
        else $error("nmi offered with wrong vector");
    irq_gate_a: assert property (irq_req |-> $past(cpu_int_enable))
        else $error("maskable offered while core disabled");
    nmi_take_a: assert property (watchdog_irq && nmi_mode_reg |-> ##[1:2] nmi_req)
        else $error("watchdog overflow not offered as nmi");
    standby_nmi_a: assert property (nmi_req |-> standby_release)
        else $error("nmi without standby release");
    ack_drop_a: assert property (cpu_ack && (nmi_req || irq_req) |=> !nmi_req && !irq_req)
        else $error("request still offered after acknowledge");
    vec_range_a: assert property (irq_req |-> !vector_addr[0] && vector_addr inside {[16'h0004:16'h002C]})
        else $error("vector outside the table");
    nmi_ack_c: cover property (nmi_req && cpu_ack);
    irq_ack_c: cover property (irq_req && cpu_ack);
    wake_c: cover property (standby_release && !irq_req && !nmi_req);
endmodule

bind vic_top vic_monitor i_mon (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
    .watchdog_irq, .cpu_int_enable, .cpu_ack, .nmi_req, .irq_req, .vector_addr, .standby_release);

//--- vic_cpu_model.sv
// core model: acknowledges an offered request and fetches its vector
`timescale 1ns/1ps
module vic_cpu_model (
    input  wire logic                 clk_sys,     // clock
    input  wire logic                 arst_n,      // reset
    input  wire logic                 ack_en,      // core may take requests
    input  wire logic                 nmi_req,     // nmi offered
    input  wire logic                 irq_req,     // irq offered
    input  wire vic_pkg::vic_vec_type vector_addr, // offered vector
    output logic                      cpu_ack,     // acknowledge pulse
    output vic_pkg::vic_vec_type      last_vec,    // fetched vector
    output logic                      last_nmi,    // last ack was nmi
    output logic [7:0]                ack_cnt      // acks so far
);
    import vic_pkg::*;
    logic [1:0] gap_reg; // spacing so the next vector has settled

    // one-cycle ack, then wait out the re-offer time
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cpu_ack <= 1'b0;
            gap_reg <= 2'h0;
            last_vec <= 16'h0000;
            last_nmi <= 1'b0;
            ack_cnt <= 8'h00;
        end else begin
            cpu_ack <= 1'b0;
            if (gap_reg != 2'h0)
                gap_reg <= gap_reg - 2'h1;
            else if (ack_en && !cpu_ack && (nmi_req || irq_req)) begin
                cpu_ack <= 1'b1;
                gap_reg <= 2'h3;
            end
            if (cpu_ack) begin
                last_vec <= vector_addr;
                last_nmi <= nmi_req;
                ack_cnt <= ack_cnt + 8'h01;
            end
        end
    end
endmodule

//--- testbench.sv
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`include "vic_defs.svh"
module testbench;
    import vic_pkg::*;
    logic clk_sys, arst_n, reg_we, reg_re, cpu_int_enable, ack_en, last_nmi, cpu_ack, nmi_req, irq_req;
    logic standby_release, watchdog_irq, pin_edge_irq_0, pin_edge_irq_1, pin_edge_irq_2, pin_edge_irq_3;
    logic remote_edge_irq, uart_rx_done_irq, serial_a_xfer_done_irq, serial_b_xfer_done_irq;
    logic uart_tx_done_irq, watch_interval_irq, timer16_match_irq, timer8a_match_irq, timer8b_match_irq;
    logic cascade_match_irq, timer8c_match_irq, conversion_done_irq, watch_overflow_irq, remote_error_irq;
    logic remote_guide_pulse_irq, remote_rx_done_irq, remote_shift_read_irq;
    vic_addr_type reg_addr;
    vic_byte_type reg_wdata, reg_rdata, d;
    vic_vec_type  vector_addr, last_vec;
    vic_src_type  m;
    logic [7:0]   key_lines, ack_cnt;
    logic [31:0]  seed;
    int           checks, err_total, p;

    // controller and core model
    vic_top i_dut (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .watchdog_irq,
        .pin_edge_irq_0, .pin_edge_irq_1, .pin_edge_irq_2, .pin_edge_irq_3, .remote_edge_irq,
        .uart_rx_done_irq, .serial_a_xfer_done_irq, .serial_b_xfer_done_irq, .uart_tx_done_irq,
        .watch_interval_irq, .timer16_match_irq, .timer8a_match_irq, .timer8b_match_irq, .cascade_match_irq,
        .timer8c_match_irq, .conversion_done_irq, .watch_overflow_irq, .key_lines, .remote_error_irq,
        .remote_guide_pulse_irq, .remote_rx_done_irq, .remote_shift_read_irq, .cpu_int_enable, .cpu_ack,
        .nmi_req, .irq_req, .vector_addr, .standby_release);
    vic_cpu_model i_cpu (.clk_sys, .arst_n, .ack_en, .nmi_req, .irq_req, .vector_addr, .cpu_ack,
        .last_vec, .last_nmi, .ack_cnt);

    // 20 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic vic_vec_type vec_of(input int k);
        return 16'h0004 + 16'(2 * k);
    endfunction
    // lowest index pending wins
    function automatic int win(input vic_src_type s);
        for (int i = 0; i < 21; i++)
            if (s[i])
                return i;
        return 0;
    endfunction
    function automatic vic_byte_type rst_val(input int a);
        return (a == 3 || a == 4) ? 8'hFF : (a == 5 ? 8'h1F : 8'h00);
    endfunction

    task automatic print_verdict();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input vic_addr_type a, input vic_byte_type v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_we <= 1'b1;
        @(posedge clk_sys);
        reg_we <= 1'b0;
        @(posedge clk_sys);
    endtask
    // data stands one cycle after the strobe
    task automatic rd(input vic_addr_type a, output vic_byte_type v);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk_sys);
        reg_re <= 1'b0;
        @(posedge clk_sys);
        v = reg_rdata;
    endtask
    task automatic wr3(input vic_addr_type a, input logic [23:0] v);
        for (int b = 0; b < 3; b++)
            wr(a + vic_addr_type'(b), v[8 * b +: 8]);
    endtask
    // one cycle of events; pins and key line pulse low
    task automatic fire(input vic_src_type s, input logic alt);
        watchdog_irq <= s[0];
        {pin_edge_irq_3, pin_edge_irq_2, pin_edge_irq_1, pin_edge_irq_0} <= ~s[4:1];
        remote_edge_irq <= s[5];
        uart_rx_done_irq <= s[6] && !alt;
        serial_a_xfer_done_irq <= s[6] && alt;
        {uart_tx_done_irq, serial_b_xfer_done_irq} <= s[8:7];
        {timer8a_match_irq, timer16_match_irq, watch_interval_irq} <= s[11:9];
        timer8b_match_irq <= s[12] && !alt;
        cascade_match_irq <= s[12] && alt;
        {watch_overflow_irq, conversion_done_irq, timer8c_match_irq} <= s[15:13];
        key_lines <= {7'h7F, ~s[16]};
        {remote_shift_read_irq, remote_rx_done_irq, remote_guide_pulse_irq, remote_error_irq} <= s[20:17];
        @(posedge clk_sys);
    endtask
    task automatic wait_ack();
        logic [7:0] n;
        n = ack_cnt;
        for (int i = 0; i < 40 && ack_cnt == n; i++)
            @(posedge clk_sys);
        if (ack_cnt == n) begin
            err_total++;
            $display("BAD %0t no acknowledge", $time);
            print_verdict();
        end
    endtask

    initial begin
        {arst_n, reg_we, reg_re, cpu_int_enable, ack_en} = 5'h00;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        seed = 32'h537D;
        checks = 0;
        err_total = 0;
        fire(21'h0, 1'b0);
        repeat (19) @(posedge clk_sys);
        arst_n <= 1'b1;
        // reset values of all offsets
        for (int a = 0; a < 16; a++) begin
            rd(vic_addr_type'(a), d);
            check(d, rst_val(a));
        end
        wr3(`VIC_ADDR_ENAB0, 24'h1FFFFF);
        wr3(`VIC_ADDR_MASK0, 24'h0);
        wr(`VIC_ADDR_KEYMODE, 8'h01);
        cpu_int_enable <= 1'b1;
        ack_en <= 1'b1;
        // each source alone, then the second source of each shared slot
        for (int k = 0; k < 23; k++) begin
            p = (k < 21) ? k : (k == 21 ? 6 : 12);
            wr(`VIC_ADDR_CTRL, (k == 22) ? 8'h02 : 8'h00);
            fire(vic_src_type'(1) << p, k > 20);
            fire(21'h0, 1'b0);
            wait_ack();
            check({last_nmi, last_vec}, {1'b0, vec_of(p)});
            rd(vic_addr_type'(p / 8), d);
            check(d, 8'h00);
        end
        ack_en <= 1'b0;
        wr(`VIC_ADDR_CTRL, 8'h00);
        // simultaneous requests: corner pairs, then random sets
        for (int n = 0; n < 24; n++) begin
            seed = xs(seed);
            m = (n == 0) ? 21'h100001 : (n == 1) ? 21'h180000 : seed[20:0];
            if (m == 21'h0)
                m = 21'h1;
            fire(m, 1'b0);
            fire(21'h0, 1'b0);
            repeat (3) @(posedge clk_sys);
            check({irq_req, vector_addr}, {1'b1, vec_of(win(m))});
            wr3(`VIC_ADDR_FLAG0, 24'h0);
        end
        // all pending: masks pick the winner and the wake
        fire(21'h1FFFFF, 1'b0);
        fire(21'h0, 1'b0);
        wr(`VIC_ADDR_MASK0, 8'h01);
        repeat (3) @(posedge clk_sys);
        check(vector_addr, vec_of(1));
        wr3(`VIC_ADDR_MASK0, 24'h1FFFFF);
        repeat (3) @(posedge clk_sys);
        check({irq_req, standby_release}, 2'b00);
        wr(`VIC_ADDR_MASK0, 8'h00);
        wr(`VIC_ADDR_ENAB0, 8'h00);
        repeat (3) @(posedge clk_sys);
        check({irq_req, standby_release}, 2'b01);
        // nmi while maskable requests wait, core disabled
        wr(`VIC_ADDR_ENAB0, 8'hFF);
        wr(`VIC_ADDR_FLAG0, 8'hFE);
        wr(`VIC_ADDR_CTRL, 8'h01);
        cpu_int_enable <= 1'b0;
        fire(21'h1, 1'b0);
        fire(21'h0, 1'b0);
        repeat (2) @(posedge clk_sys);
        check({nmi_req, irq_req, standby_release, vector_addr}, {3'b101, 16'h0004});
        rd(`VIC_ADDR_FLAG0, d);
        check(d, 8'hFE);
        ack_en <= 1'b1;
        wait_ack();
        check({last_nmi, last_vec}, 17'h10004);
        ack_en <= 1'b0;
        wr(`VIC_ADDR_CTRL, 8'h00);
        // every pin under each edge mode: a fall, then a rise
        for (int e = 0; e < 4; e++) begin
            wr(`VIC_ADDR_EXTMODE0, 8'(e * 5));
            wr(`VIC_ADDR_EXTMODE1, 8'(e * 5));
            for (int lv = 0; lv < 2; lv++) begin
                wr(`VIC_ADDR_FLAG0, 8'h00);
                {pin_edge_irq_3, pin_edge_irq_2, pin_edge_irq_1, pin_edge_irq_0} <= {4{lv[0]}};
                repeat (2) @(posedge clk_sys);
                rd(`VIC_ADDR_FLAG0, d);
                check(d[4:1], {4{e == 3 || e == lv}});
            end
        end
        print_verdict();
    end
endmodule
